// file: core/sti_pins.sv
`timescale 1ns/1ps
`default_nettype none
module sti_pins
    import sti_pkg::*;
#(
    parameter int MS_CYCLES      = sti_pkg::MS_TICK_CYC,
    parameter int LEVEL_HOLD_CYC = sti_pkg::LEVEL_HOLD_CYC
) (
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic [31:0]      prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic        scan_trigger_in_low,
    input  wire logic        engine_reset_in_low,
    input  wire logic        decode_ok,
    output logic             beeper_tone_out,
    output logic             good_read_lamp_out_low,
    output logic             reset_pullup_en,
    output logic             engine_reset_active,
    output logic             session_active
);
    import sti_pkg::*;

    logic        trig_q;
    logic        rst_q;
    logic        srst;
    logic        tick;
    logic [13:0] ms_cnt_reg;
    sti_ctrl_t   ctrl_reg;
    logic [15:0] tone_ms_reg;
    logic [15:0] tone_half_reg;
    logic [15:0] lamp_ms_reg;
    logic [15:0] tmo_ms_reg;
    logic [1:0]  evt_reg;
    logic [1:0]  evt_next;
    sti_state_t  state_reg;
    sti_state_t  state_next;
    logic [17:0] hold_cnt_reg;
    logic [15:0] tmo_cnt_reg;
    logic        good_read;
    logic        timeout;
    logic        lamp_on;
    logic [15:0] lamp_cnt_reg;
    logic        gr_tone_reg;
    logic [15:0] tone_cnt_reg;
    logic [10:0] pwr_cnt_reg;
    logic        pwr_tone;
    logic        tone_run;
    logic [15:0] tone_half;
    logic        access;
    logic        wr;
    logic        mapped;
    logic [31:0] rd_mux;

    // ************************************************************
    // Pin synchronisers and engine reset
    // ************************************************************
    sti_sync #(.RST_VAL(1'b1)) u_sync_trig (
        .pclk    (pclk),
        .presetn (presetn),
        .d       (scan_trigger_in_low),
        .q       (trig_q)
    );

    sti_sync #(.RST_VAL(1'b1)) u_sync_rst (
        .pclk    (pclk),
        .presetn (presetn),
        .d       (engine_reset_in_low),
        .q       (rst_q)
    );

    // Reset pin low clears all functional state, registers included
    assign srst = ~rst_q;

    // Pull-up stays on and reset status follows the pin
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            reset_pullup_en     <= 1'b0;
            engine_reset_active <= 1'b0;
        end
        else
        begin
            reset_pullup_en     <= 1'b1;
            engine_reset_active <= srst;
        end
    end

    // ************************************************************
    // Millisecond timebase
    // ************************************************************
    assign tick = (ms_cnt_reg == 14'(MS_CYCLES - 1));

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            ms_cnt_reg <= 14'h0000;
        else if (srst || tick)
            ms_cnt_reg <= 14'h0000;
        else
            ms_cnt_reg <= ms_cnt_reg + 14'h0001;
    end

    // ************************************************************
    // APB slave, one wait state
    // ************************************************************
    assign access = psel & penable & pready;
    assign wr     = access & pwrite;
    assign mapped = (paddr == OFS_CTRL) || (paddr == OFS_TONE_MS) || (paddr == OFS_TONE_HALF) ||
                    (paddr == OFS_LAMP_MS) || (paddr == OFS_SESS_TMO) || (paddr == OFS_STATUS);

    // Read multiplexer, unmapped reads give zero
    always_comb
    begin
        rd_mux = 32'h0000_0000;
        unique case (paddr)
            OFS_CTRL:      rd_mux = {28'h0000000, ctrl_reg};
            OFS_TONE_MS:   rd_mux = {16'h0000, tone_ms_reg};
            OFS_TONE_HALF: rd_mux = {16'h0000, tone_half_reg};
            OFS_LAMP_MS:   rd_mux = {16'h0000, lamp_ms_reg};
            OFS_SESS_TMO:  rd_mux = {16'h0000, tmo_ms_reg};
            OFS_STATUS:    rd_mux = {25'h0000000, evt_reg, (pwr_cnt_reg == 11'(PWR_DELAY_MS + PWR_TONE_MS)),
                                     trig_q, lamp_on, gr_tone_reg, session_active};
            default:       rd_mux = 32'h0000_0000;
        endcase
    end

    // Answer one cycle into the access phase
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
            prdata  <= 32'h0000_0000;
        end
        else
        begin
            pready  <= psel & penable & ~pready;
            pslverr <= psel & penable & ~pready & ~mapped;
            prdata  <= (psel & penable & ~pready & ~pwrite) ? rd_mux : 32'h0000_0000;
        end
    end

    // Configuration registers
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            ctrl_reg      <= CTRL_RST;
            tone_ms_reg   <= GR_TONE_MS_RST;
            tone_half_reg <= GR_TONE_HALF_RST;
            lamp_ms_reg   <= LAMP_MS_RST;
            tmo_ms_reg    <= SESS_TMO_MS_RST;
        end
        else if (srst)
        begin
            ctrl_reg      <= CTRL_RST;
            tone_ms_reg   <= GR_TONE_MS_RST;
            tone_half_reg <= GR_TONE_HALF_RST;
            lamp_ms_reg   <= LAMP_MS_RST;
            tmo_ms_reg    <= SESS_TMO_MS_RST;
        end
        else if (wr)
        begin
            if (paddr == OFS_CTRL)
                ctrl_reg <= pwdata[3:0];
            if (paddr == OFS_TONE_MS)
                tone_ms_reg <= pwdata[15:0];
            if (paddr == OFS_TONE_HALF)
                tone_half_reg <= pwdata[15:0];
            if (paddr == OFS_LAMP_MS)
                lamp_ms_reg <= pwdata[15:0];
            if (paddr == OFS_SESS_TMO)
                tmo_ms_reg <= pwdata[15:0];
        end
    end

    // Sticky events, write one to clear, a new event wins
    always_comb
    begin
        evt_next = evt_reg;
        if (wr && paddr == OFS_STATUS)
            evt_next = evt_reg & ~pwdata[6:5];
        if (good_read)
            evt_next[EVT_GOOD_READ] = 1'b1;
        if (timeout)
            evt_next[EVT_TIMEOUT] = 1'b1;
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            evt_reg <= 2'b00;
        else if (srst)
            evt_reg <= 2'b00;
        else
            evt_reg <= evt_next;
    end

    // ************************************************************
    // Trigger and decode session
    // ************************************************************
    assign good_read = (state_reg == ST_SCAN) && decode_ok;
    assign timeout   = (state_reg == ST_SCAN) && ctrl_reg.pulse_mode && tick &&
                       (tmo_cnt_reg <= 16'h0001) && !decode_ok;

    // Session sequencing per trigger mode
    always_comb
    begin
        state_next = state_reg;
        unique case (state_reg)
            ST_IDLE:
                if (!trig_q)
                    state_next = ctrl_reg.pulse_mode ? ST_ARMED : ST_HOLD;
            ST_HOLD:
                if (trig_q)
                    state_next = ST_IDLE;
                else if (hold_cnt_reg == 18'(LEVEL_HOLD_CYC))
                    state_next = ST_SCAN;
            ST_ARMED:
                if (trig_q)
                    state_next = ST_SCAN;
            ST_SCAN:
                if (good_read)
                    state_next = ST_IDLE;
                else if (!ctrl_reg.pulse_mode && trig_q)
                    state_next = ST_IDLE;
                else if (timeout)
                    state_next = ST_IDLE;
        endcase
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            state_reg      <= ST_IDLE;
            session_active <= 1'b0;
        end
        else if (srst)
        begin
            state_reg      <= ST_IDLE;
            session_active <= 1'b0;
        end
        else
        begin
            state_reg      <= state_next;
            session_active <= (state_next == ST_SCAN);
        end
    end

    // Low-time counter for level mode and timeout from release
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            hold_cnt_reg <= 18'h00000;
            tmo_cnt_reg  <= 16'h0000;
        end
        else if (srst)
        begin
            hold_cnt_reg <= 18'h00000;
            tmo_cnt_reg  <= 16'h0000;
        end
        else
        begin
            hold_cnt_reg <= (state_reg == ST_HOLD && !trig_q) ? hold_cnt_reg + 18'h00001 : 18'h00000;
            if (state_reg == ST_ARMED && trig_q)
                tmo_cnt_reg <= tmo_ms_reg;
            else if (tick && tmo_cnt_reg != 16'h0000)
                tmo_cnt_reg <= tmo_cnt_reg - 16'h0001;
        end
    end

    // ************************************************************
    // Good-read lamp
    // ************************************************************
    assign lamp_on = ~good_read_lamp_out_low;

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            good_read_lamp_out_low <= 1'b1;
            lamp_cnt_reg           <= 16'h0000;
        end
        else if (srst)
        begin
            good_read_lamp_out_low <= 1'b1;
            lamp_cnt_reg           <= 16'h0000;
        end
        else if (good_read && ctrl_reg.lamp_en)
        begin
            good_read_lamp_out_low <= 1'b0;
            lamp_cnt_reg           <= lamp_ms_reg;
        end
        else if (lamp_on && tick)
        begin
            lamp_cnt_reg <= lamp_cnt_reg - 16'h0001;
            if (lamp_cnt_reg <= 16'h0001)
                good_read_lamp_out_low <= 1'b1;
        end
    end

    // ************************************************************
    // Beeper: good-read and power-on tones
    // ************************************************************
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            gr_tone_reg  <= 1'b0;
            tone_cnt_reg <= 16'h0000;
        end
        else if (srst)
        begin
            gr_tone_reg  <= 1'b0;
            tone_cnt_reg <= 16'h0000;
        end
        else if (good_read && ctrl_reg.tone_en)
        begin
            gr_tone_reg  <= 1'b1;
            tone_cnt_reg <= tone_ms_reg;
        end
        else if (gr_tone_reg && tick)
        begin
            tone_cnt_reg <= tone_cnt_reg - 16'h0001;
            if (tone_cnt_reg <= 16'h0001)
                gr_tone_reg <= 1'b0;
        end
    end

    // Power-on sequence counts milliseconds up to the end of the tone
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            pwr_cnt_reg <= 11'h000;
        else if (srst)
            pwr_cnt_reg <= 11'h000;
        else if (tick && pwr_cnt_reg != 11'(PWR_DELAY_MS + PWR_TONE_MS))
            pwr_cnt_reg <= pwr_cnt_reg + 11'h001;
    end

    assign pwr_tone  = ctrl_reg.pwr_tone_en && (pwr_cnt_reg >= 11'(PWR_DELAY_MS)) &&
                       (pwr_cnt_reg < 11'(PWR_DELAY_MS + PWR_TONE_MS));
    assign tone_run  = gr_tone_reg | pwr_tone;
    assign tone_half = gr_tone_reg ? tone_half_reg : PWR_TONE_HALF;

    sti_tone u_tone (
        .pclk    (pclk),
        .presetn (presetn),
        .run     (tone_run),
        .half    (tone_half),
        .tone    (beeper_tone_out)
    );

    // ************************************************************
    // Checks
    // ************************************************************
    chk_tone_start: assert property (@(posedge pclk) disable iff (!presetn)
        good_read && ctrl_reg.tone_en && !srst |=> gr_tone_reg && tone_cnt_reg == $past(tone_ms_reg))
        else $error("good-read tone did not start");
    chk_tone_disabled: assert property (@(posedge pclk) disable iff (!presetn)
        $rose(gr_tone_reg) |-> $past(good_read && ctrl_reg.tone_en))
        else $error("tone started while disabled");
    chk_lamp_on_read: assert property (@(posedge pclk) disable iff (!presetn)
        good_read && ctrl_reg.lamp_en && !srst |=> !good_read_lamp_out_low)
        else $error("lamp not driven low on good read");
    chk_lamp_disabled: assert property (@(posedge pclk) disable iff (!presetn)
        $fell(good_read_lamp_out_low) |-> $past(good_read && ctrl_reg.lamp_en))
        else $error("lamp lit without enabled good read");
    chk_reset_pin: assert property (@(posedge pclk) disable iff (!presetn)
        srst |=> !session_active && good_read_lamp_out_low && engine_reset_active && !gr_tone_reg)
        else $error("reset pin did not reset engine");
    chk_pullup_held: assert property (@(posedge pclk) disable iff (!presetn)
        $past(presetn) |-> reset_pullup_en)
        else $error("pull-up released");
    chk_level_start: assert property (@(posedge pclk) disable iff (!presetn)
        $rose(session_active) && !ctrl_reg.pulse_mode |-> $past(hold_cnt_reg) == 18'(LEVEL_HOLD_CYC))
        else $error("level session started early");
    chk_level_end: assert property (@(posedge pclk) disable iff (!presetn)
        state_reg == ST_SCAN && !ctrl_reg.pulse_mode && trig_q |=> !session_active)
        else $error("level session kept after release");
    chk_pulse_start: assert property (@(posedge pclk) disable iff (!presetn)
        $rose(session_active) && ctrl_reg.pulse_mode |-> $past(state_reg == ST_ARMED && trig_q))
        else $error("pulse session without release");
    chk_timeout_quiet: assert property (@(posedge pclk) disable iff (!presetn)
        timeout && !srst |=> !session_active && !$fell(good_read_lamp_out_low) && !$rose(gr_tone_reg))
        else $error("timeout kept session or gave indication");
    chk_pwr_tone: assert property (@(posedge pclk) disable iff (!presetn)
        pwr_tone && !gr_tone_reg |-> tone_half == PWR_TONE_HALF && tone_run)
        else $error("power-on tone wrong");
endmodule
`default_nettype wire

// file: inc/sti_pkg.sv
`default_nettype none
package sti_pkg;

    // ************************************************************
    // Timebase
    // ************************************************************
    localparam int CLK_HZ             = 10000000;
    localparam int MS_TICK_MS         = 1;
    localparam int MS_TICK_CYC        = CLK_HZ / 1000 * MS_TICK_MS;
    localparam int LEVEL_HOLD_MS      = 20;
    localparam int LEVEL_HOLD_CYC     = LEVEL_HOLD_MS * (CLK_HZ / 1000);

    // ************************************************************
    // Tones and lamp
    // ************************************************************
    localparam int PWR_DELAY_MS       = 970;
    localparam int PWR_TONE_MS        = 400;
    localparam int PWR_TONE_HZ        = 4184;
    localparam logic [15:0] PWR_TONE_HALF  = 16'(CLK_HZ / (2 * PWR_TONE_HZ));
    localparam int GR_TONE_HZ         = 2730;
    localparam logic [15:0] GR_TONE_HALF_RST = 16'(CLK_HZ / (2 * GR_TONE_HZ));
    localparam logic [15:0] GR_TONE_MS_RST   = 16'h0050;
    localparam logic [15:0] LAMP_MS_RST      = 16'h0014;
    localparam logic [15:0] SESS_TMO_MS_RST  = 16'h1388;

    // ************************************************************
    // Register map (byte offsets)
    // ************************************************************
    localparam logic [7:0] OFS_CTRL       = 8'h00;
    localparam logic [7:0] OFS_TONE_MS    = 8'h04;
    localparam logic [7:0] OFS_TONE_HALF  = 8'h08;
    localparam logic [7:0] OFS_LAMP_MS    = 8'h0C;
    localparam logic [7:0] OFS_SESS_TMO   = 8'h10;
    localparam logic [7:0] OFS_STATUS     = 8'h14;

    // Control fields: bit0 tone, bit1 lamp, bit2 power-on tone, bit3 pulse mode
    typedef struct packed {
        logic pulse_mode;
        logic pwr_tone_en;
        logic lamp_en;
        logic tone_en;
    } sti_ctrl_t;
    localparam sti_ctrl_t CTRL_RST = 4'h7;

    // Status event bit positions
    localparam int EVT_GOOD_READ = 0;
    localparam int EVT_TIMEOUT   = 1;

    typedef enum logic [1:0] {
        ST_IDLE  = 2'b00,
        ST_HOLD  = 2'b01,
        ST_ARMED = 2'b10,
        ST_SCAN  = 2'b11
    } sti_state_t;

endpackage
`default_nettype wire

// file: core/sti_sync.sv
`timescale 1ns/1ps
`default_nettype none
// Two-stage synchroniser for a pin level
module sti_sync #(
    parameter logic RST_VAL = 1'b1
) (
    input  wire logic pclk,
    input  wire logic presetn,
    input  wire logic d,
    output logic      q
);
    logic meta_reg;

    // ************************************************************
    // Synchroniser stages
    // ************************************************************
    // Only the second stage is visible outside
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            meta_reg <= RST_VAL;
            q        <= RST_VAL;
        end
        else
        begin
            meta_reg <= d;
            q        <= meta_reg;
        end
    end
endmodule
`default_nettype wire

// file: core/sti_tone.sv
`timescale 1ns/1ps
`default_nettype none
// Square-wave tone generator, half period in clock cycles
module sti_tone (
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        run,
    input  wire logic [15:0] half,
    output logic             tone
);
    logic [15:0] cnt_reg;

    // ************************************************************
    // Half-period counter and output toggle
    // ************************************************************
    // Output rests low whenever the tone is stopped
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            cnt_reg <= 16'h0000;
            tone    <= 1'b0;
        end
        else if (!run)
        begin
            cnt_reg <= 16'h0000;
            tone    <= 1'b0;
        end
        else if (cnt_reg + 16'h0001 >= half)
        begin
            cnt_reg <= 16'h0000;
            tone    <= ~tone;
        end
        else
        begin
            cnt_reg <= cnt_reg + 16'h0001;
        end
    end
endmodule
`default_nettype wire

// file: verification/sti_host_model.sv
`timescale 1ns/1ps
`default_nettype none
// ********
// Host GPIO model for trigger and reset pins
// ********
module sti_host_model (
    input  wire logic pclk,
    output logic      trig_low,
    output logic      rst_low
);
    // Released lines: reset floats to the weak pull-up level
    initial
    begin
        trig_low = 1'b1;
        rst_low  = 1'b1;
    end

    // Trigger held low for n cycles, then released
    task automatic trig(input int n);
        trig_low <= 1'b0;
        repeat (n) @(posedge pclk);
        trig_low <= 1'b1;
    endtask

    // Reset pulse of 2000 cycles, 200 us at 100 ns
    task automatic reset_pulse();
        rst_low <= 1'b0;
        repeat (2000) @(posedge pclk);
        rst_low <= 1'b1;
    endtask
endmodule
`default_nettype wire

// file: verification/sti_pins_tb.sv
`timescale 1ns/1ps
`default_nettype none
module sti_pins_tb;
    import sti_pkg::*;
    localparam int MS = 10;
    logic        pclk;
    logic        presetn;
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [7:0]  paddr;
    logic [31:0] pwdata;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic        trig_low;
    logic        rst_low;
    logic        decode_ok;
    logic        beep;
    logic        lamp;
    logic        pull;
    logic        eng_rst;
    logic        sess;
    int          n_errors;
    int          cmp_count;

    // ********
    // Clock, design and host model
    // ********
    initial
    begin
        pclk = 1'b0;
    end
    always #50 pclk = ~pclk;

    sti_pins #(.MS_CYCLES(MS), .LEVEL_HOLD_CYC(50)) i_sti_pins (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .scan_trigger_in_low(trig_low), .engine_reset_in_low(rst_low), .decode_ok(decode_ok),
        .beeper_tone_out(beep), .good_read_lamp_out_low(lamp), .reset_pullup_en(pull),
        .engine_reset_active(eng_rst), .session_active(sess));
    sti_host_model i_sti_host_model (.pclk(pclk), .trig_low(trig_low), .rst_low(rst_low));

    // ********
    // Checking and bus tasks
    // ********
    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp)
        begin
            n_errors++;
            $display("[ERR] %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    task automatic in_rng(input string nm, input int n, input int lo, input int hi);
        chk(nm, 32'(n >= lo && n <= hi), 32'h1);
    endtask

    task automatic tally_and_finish();
        $display("comparisons %0d mismatches %0d", cmp_count, n_errors);
        if (n_errors == 0 && cmp_count > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask

    // One APB transfer, held until pready is sampled high
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                       output logic [31:0] r, output logic e);
        int k;
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d;
        @(posedge pclk);
        penable <= 1'b1;
        for (k = 0; k < 20; k++)
        begin
            @(posedge pclk);
            if (pready === 1'b1)
                break;
        end
        r = prdata;
        e = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
        pwrite  <= 1'($urandom);
        paddr   <= 8'($urandom);
        pwdata  <= $urandom;
        // Idle edge keeps the next setup out of this time step
        @(posedge pclk);
        if (k == 20)
        begin
            chk("pready", 32'h0, 32'h1);
            tally_and_finish();
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] r;
        logic        e;
        apb(1'b1, a, d, r, e);
    endtask

    task automatic rd_chk(input string nm, input logic [7:0] a, input logic [31:0] m,
                          input logic [31:0] x, input logic err);
        logic [31:0] r;
        logic        e;
        apb(1'b0, a, 32'h0, r, e);
        chk(nm, r & m, x);
        chk({nm, "_slverr"}, 32'(e), 32'(err));
    endtask

    // Cycles during which the chosen output keeps a level, bounded
    function automatic logic sig(input int s);
        return (s == 0) ? sess : ((s == 1) ? lamp : beep);
    endfunction

    task automatic meas(input int s, input logic lv, output int n);
        n = 0;
        while (sig(s) === lv && n < 20000)
        begin
            @(posedge pclk);
            n++;
        end
        if (n == 20000)
        begin
            chk("wait_bound", 32'h0, 32'h1);
            tally_and_finish();
        end
    endtask

    // Good read: lamp low time and one tone high phase in parallel
    task automatic good_read(output int nl, output int nh);
        int x;
        decode_ok <= 1'b1;
        @(posedge pclk);
        decode_ok <= 1'b0;
        @(posedge pclk);
        fork
            meas(1, 1'b0, nl);
            begin
                meas(2, 1'b0, x);
                meas(2, 1'b1, nh);
            end
        join
    endtask

    // Any indication seen over c cycles
    task automatic quiet(input int c, output logic any);
        any = 1'b0;
        repeat (c)
        begin
            @(posedge pclk);
            any = any | beep | ~lamp;
        end
    endtask

    // Watchdog against hangs
    initial
    begin
        repeat (60000) @(posedge pclk);
        chk("watchdog", 32'h0, 32'h1);
        tally_and_finish();
    end

    // ********
    // Main sequence
    // ********
    initial
    begin
        int   n;
        int   n2;
        int   nh;
        int   tl;
        int   tm;
        int   hf;
        logic any;
        n_errors  = 0;
        cmp_count = 0;
        presetn   = 1'b0;
        psel      = 1'b0;
        penable   = 1'b0;
        decode_ok = 1'b0;
        void'($urandom(32'h007531AC));
        pwrite    = 1'($urandom);
        paddr     = 8'($urandom);
        pwdata    = $urandom;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        rd_chk("ctrl", OFS_CTRL, 32'hF, 32'h7, 1'b0);
        rd_chk("tone_ms", OFS_TONE_MS, 32'hFFFF, 32'd80, 1'b0);
        rd_chk("tone_half", OFS_TONE_HALF, 32'hFFFF, {16'h0, GR_TONE_HALF_RST}, 1'b0);
        rd_chk("lamp_ms", OFS_LAMP_MS, 32'hFFFF, 32'd20, 1'b0);
        rd_chk("unmapped", 8'h18, 32'hFFFFFFFF, 32'h0, 1'b1);
        tm = 3 + $urandom % 3;
        tl = 2 + $urandom % 4;
        hf = 3 + $urandom % 6;
        wr(OFS_CTRL, 32'h3);
        wr(OFS_TONE_MS, 32'(tm));
        wr(OFS_TONE_HALF, 32'(hf));
        wr(OFS_LAMP_MS, 32'(tl));
        wr(OFS_SESS_TMO, 32'h3);
        rd_chk("lamp_rb", OFS_LAMP_MS, 32'hFFFF, 32'(tl), 1'b0);
        $display("registers done");
        i_sti_host_model.trig(40);
        repeat (20) @(posedge pclk);
        chk("short_pull", 32'(sess), 32'h0);
        fork
            i_sti_host_model.trig(100);
        join_none
        meas(0, 1'b0, n);
        in_rng("level_start", n, 51, 60);
        meas(0, 1'b1, n2);
        in_rng("level_release", n + n2, 101, 108);
        fork
            i_sti_host_model.trig(80);
        join_none
        meas(0, 1'b0, n);
        good_read(n, nh);
        chk("gr_end", 32'(sess), 32'h0);
        in_rng("lamp_len", n, (tl - 1) * MS, tl * MS + 2);
        in_rng("tone_half", nh, hf - 1, hf + 1);
        repeat (tm * MS) @(posedge pclk);
        quiet(30, any);
        chk("tone_over", 32'(any), 32'h0);
        $display("level mode done");
        wr(OFS_CTRL, 32'h0);
        fork
            i_sti_host_model.trig(80);
        join_none
        meas(0, 1'b0, n);
        decode_ok <= 1'b1;
        @(posedge pclk);
        decode_ok <= 1'b0;
        quiet(100, any);
        chk("disabled", 32'(any), 32'h0);
        $display("disable done");
        wr(OFS_CTRL, 32'hB);
        i_sti_host_model.trig(500);
        meas(0, 1'b0, n);
        in_rng("pulse_start", n, 1, 8);
        good_read(n, nh);
        chk("pulse_gr_end", 32'(sess), 32'h0);
        repeat ((tl + tm) * MS) @(posedge pclk);
        i_sti_host_model.trig(500);
        meas(0, 1'b0, n);
        meas(0, 1'b1, n);
        in_rng("timeout_len", n, 2 * MS, 4 * MS + 3);
        chk("timeout_lamp", 32'(lamp), 32'h1);
        rd_chk("timeout_evt", OFS_STATUS, 32'h60, 32'h60, 1'b0);
        wr(OFS_STATUS, 32'h60);
        rd_chk("evt_clear", OFS_STATUS, 32'h60, 32'h0, 1'b0);
        $display("pulse mode done");
        wr(OFS_CTRL, 32'h0);
        fork
            i_sti_host_model.reset_pulse();
            begin
                repeat (10) @(posedge pclk);
                chk("eng_reset", 32'(eng_rst), 32'h1);
            end
        join
        chk("pullup", 32'(pull), 32'h1);
        meas(2, 1'b0, n);
        // First high phase starts one half period after the delay
        in_rng("pwr_delay", n, PWR_DELAY_MS * MS + int'(PWR_TONE_HALF) - 20,
               PWR_DELAY_MS * MS + int'(PWR_TONE_HALF) + 20);
        meas(2, 1'b1, nh);
        in_rng("pwr_half", nh, int'(PWR_TONE_HALF) - 1, int'(PWR_TONE_HALF) + 1);
        rd_chk("ctrl_after_pin", OFS_CTRL, 32'hF, 32'h7, 1'b0);
        $display("reset pin done");
        tally_and_finish();
    end
endmodule
`default_nettype wire
